//--- verilog/i2c_hold_params.svh
`ifndef I2C_HOLD_PARAMS_SVH
`define I2C_HOLD_PARAMS_SVH

// Register byte offsets on the AXI4-Lite bus
`define REG_CTRL_LO 8'h00
`define REG_CTRL_HI 8'h04
`define REG_STATUS 8'h08
`define REG_OWN_ADDR 8'h0C
`define REG_RECEIVE 8'h10
`define REG_TRANSMIT 8'h14
`define REG_INT_STAT 8'h18
`define REG_INT_MASK 8'h1C

// Field positions
`define CTL_ENABLE_BIT 15
`define CTL_RELEASE_BIT 12
`define OPT_OVERWRITE_BIT 4
`define OPT_HOLD_TIME_BIT 3
`define OPT_COLLISION_BIT 2
`define OPT_ADDR_HOLD_BIT 1
`define OPT_DATA_HOLD_BIT 0
`define STAT_COLLISION_BIT 10
`define STAT_OVERFLOW_BIT 6
`define STAT_READ_BIT 2
`define STAT_FULL_BIT 1
`define INT_RX_BIT 0
`define INT_COLLISION_BIT 1
`define INT_HOLD_BIT 2

// Reset values
`define OWN_ADDR_RST 7'h2A
`define OPTIONS_RST 5'h00

// Timing
`define CLK_MHZ 40
`define HOLD_LONG_NS 300
`define HOLD_SHORT_NS 100
`define HOLD_LONG_CYC ((`HOLD_LONG_NS * `CLK_MHZ + 999) / 1000)
`define HOLD_SHORT_CYC ((`HOLD_SHORT_NS * `CLK_MHZ + 999) / 1000)

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- verilog/i2c_hold_pkg.sv
package i2c_hold_pkg;

  typedef enum logic [2:0] {
    PH_IDLE, PH_ADDR, PH_ADDR_ACK, PH_RX, PH_RX_ACK, PH_TX, PH_TX_ACK
  } slave_phase_t;

  typedef struct packed {
    logic [2:0] ff;
    logic level;
  } sync_state_t;

  typedef struct packed {
    logic [5:0] cnt;
  } timer_state_t;

  typedef struct packed {
    slave_phase_t phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] tx_byte;
    logic [7:0] rcv;
    logic [6:0] own_addr;
    logic enable;
    logic clock_release;
    logic [4:0] options;
    logic receive_buffer_full;
    logic ov;
    logic bus_collision_flag;
    logic rw;
    logic acked;
    logic scl_prev;
    logic sda_prev;
    logic sda_want;
    logic sda_low;
    logic [2:0] int_stat;
    logic [2:0] int_mask;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } slave_state_t;

endpackage

//--- verilog/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Pin and its clean level
  input wire logic i_pin,
  output logic o_level
);

  i2c_hold_pkg::sync_state_t st_r;
  i2c_hold_pkg::sync_state_t st_nxt;

  // A change counts only once the second and third stage agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.ff = {st_r.ff[1:0], i_pin};
    if (st_r.ff[1] == st_r.ff[2]) begin
      st_nxt.level = st_r.ff[2];
    end
  end

  // The bus idles high, so reset to released
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_level = st_r.level;

endmodule

`default_nettype wire

//--- verilog/sda_hold_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2c_hold_params.svh"

module sda_hold_timer #(
  parameter int CNT_W = 6
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Control
  input wire logic i_start,
  input wire logic i_long,
  output logic o_busy
);

  localparam int LONG_CYC = `HOLD_LONG_CYC;
  localparam int SHORT_CYC = `HOLD_SHORT_CYC;

  if (LONG_CYC >= (1 << CNT_W) || SHORT_CYC < 1) begin : g_bad_width
    $error("sda_hold_timer: CNT_W too small for hold count");
  end

  i2c_hold_pkg::timer_state_t st_r;
  i2c_hold_pkg::timer_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (i_start) begin
      st_nxt.cnt = i_long ? CNT_W'(LONG_CYC) : CNT_W'(SHORT_CYC);
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_busy = (st_r.cnt != '0);

endmodule

`default_nettype wire

//--- verilog/i2c_slave_hold.sv
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_hold_params.svh"

module i2c_slave_hold (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // I2C pins, open drain
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // AXI4-Lite write
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Interrupt
  output logic o_irq
);

  i2c_hold_pkg::slave_state_t st_r;
  i2c_hold_pkg::slave_state_t st_nxt;
  logic scl_s;
  logic sda_s;
  logic hold_busy;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic byte_end;
  logic accept;
  logic coll_ev;
  logic tx_phase;
  logic [15:0] tx_merge;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = old;
    if (s[0]) begin
      merge16[7:0] = d[7:0];
    end
    if (s[1]) begin
      merge16[15:8] = d[15:8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  pin_sync u_scl_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_pin(i_scl),
    .o_level(scl_s)
  );

  pin_sync u_sda_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_pin(i_sda),
    .o_level(sda_s)
  );

  sda_hold_timer u_hold (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_start(scl_fall),
    .i_long(st_r.options[`OPT_HOLD_TIME_BIT]),
    .o_busy(hold_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign scl_rise = scl_s & ~st_r.scl_prev;
  assign scl_fall = ~scl_s & st_r.scl_prev;
  assign start_ev = st_r.enable & scl_s & st_r.scl_prev & st_r.sda_prev & ~sda_s;
  assign stop_ev = st_r.enable & scl_s & st_r.scl_prev & ~st_r.sda_prev & sda_s;
  assign byte_end = scl_fall && (st_r.bit_cnt == 4'h8);
  // Byte lanes merged outside the process; a call result cannot be part-selected
  assign tx_merge = merge16({8'h00, st_r.tx_byte}, st_r.w_data, st_r.w_strb);
  // Overwrite mode ignores a stale overflow, but never a full buffer
  assign accept = st_r.options[`OPT_OVERWRITE_BIT] ? ~st_r.receive_buffer_full : (~st_r.receive_buffer_full & ~st_r.ov);
  assign tx_phase = (st_r.phase == i2c_hold_pkg::PH_TX) || (st_r.phase == i2c_hold_pkg::PH_ADDR_ACK)
                    || (st_r.phase == i2c_hold_pkg::PH_RX_ACK);
  assign coll_ev = st_r.options[`OPT_COLLISION_BIT] && tx_phase && scl_rise
                   && st_r.sda_want && ~sda_s;

  always_comb begin
    st_nxt = st_r;
    st_nxt.scl_prev = scl_s;
    st_nxt.sda_prev = sda_s;

    // Bus slave: write address and data may arrive in either order
    if (o_awready && i_awvalid) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = i_awaddr;
    end
    if (o_wready && i_wvalid) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = i_wdata;
      st_nxt.w_strb = i_wstrb;
    end
    if (st_r.bvalid && i_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.aw_got && st_r.w_got) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = `RESP_OKAY;
      if (st_r.aw_addr[7:2] == `REG_CTRL_LO >> 2) begin
        st_nxt.enable = st_r.w_strb[1] ? st_r.w_data[`CTL_ENABLE_BIT] : st_r.enable;
        st_nxt.clock_release = st_r.w_strb[1] ? st_r.w_data[`CTL_RELEASE_BIT] : st_r.clock_release;
      end else if (st_r.aw_addr[7:2] == `REG_CTRL_HI >> 2) begin
        st_nxt.options = st_r.w_strb[0] ? st_r.w_data[4:0] : st_r.options;
      end else if (st_r.aw_addr[7:2] == `REG_STATUS >> 2) begin
        st_nxt.bus_collision_flag = st_r.bus_collision_flag & ~(st_r.w_strb[1] & st_r.w_data[`STAT_COLLISION_BIT]);
        st_nxt.ov = st_r.ov & ~(st_r.w_strb[0] & st_r.w_data[`STAT_OVERFLOW_BIT]);
      end else if (st_r.aw_addr[7:2] == `REG_OWN_ADDR >> 2) begin
        st_nxt.own_addr = st_r.w_strb[0] ? st_r.w_data[6:0] : st_r.own_addr;
      end else if (st_r.aw_addr[7:2] == `REG_TRANSMIT >> 2) begin
        st_nxt.tx_byte = tx_merge[7:0];
      end else if (st_r.aw_addr[7:2] == `REG_INT_STAT >> 2) begin
        st_nxt.int_stat = st_r.int_stat & ~(st_r.w_data[2:0] & {3{st_r.w_strb[0]}});
      end else if (st_r.aw_addr[7:2] == `REG_INT_MASK >> 2) begin
        st_nxt.int_mask = st_r.w_strb[0] ? st_r.w_data[2:0] : st_r.int_mask;
      end else if (st_r.aw_addr[7:2] != `REG_RECEIVE >> 2) begin
        st_nxt.bresp = `RESP_SLVERR;
      end
    end

    // Bus slave: read side; reading the receive register empties it
    if (st_r.rvalid && i_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (o_arready && i_arvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = `RESP_OKAY;
      st_nxt.rdata = 32'h0000_0000;
      if (i_araddr[7:2] == `REG_CTRL_LO >> 2) begin
        st_nxt.rdata[`CTL_ENABLE_BIT] = st_r.enable;
        st_nxt.rdata[`CTL_RELEASE_BIT] = st_r.clock_release;
      end else if (i_araddr[7:2] == `REG_CTRL_HI >> 2) begin
        st_nxt.rdata[4:0] = st_r.options;
      end else if (i_araddr[7:2] == `REG_STATUS >> 2) begin
        st_nxt.rdata[`STAT_COLLISION_BIT] = st_r.bus_collision_flag;
        st_nxt.rdata[`STAT_OVERFLOW_BIT] = st_r.ov;
        st_nxt.rdata[`STAT_READ_BIT] = st_r.rw;
        st_nxt.rdata[`STAT_FULL_BIT] = st_r.receive_buffer_full;
      end else if (i_araddr[7:2] == `REG_OWN_ADDR >> 2) begin
        st_nxt.rdata[6:0] = st_r.own_addr;
      end else if (i_araddr[7:2] == `REG_RECEIVE >> 2) begin
        st_nxt.rdata[7:0] = st_r.rcv;
        st_nxt.receive_buffer_full = 1'b0;
      end else if (i_araddr[7:2] == `REG_TRANSMIT >> 2) begin
        st_nxt.rdata[7:0] = st_r.tx_byte;
      end else if (i_araddr[7:2] == `REG_INT_STAT >> 2) begin
        st_nxt.rdata[2:0] = st_r.int_stat;
      end else if (i_araddr[7:2] == `REG_INT_MASK >> 2) begin
        st_nxt.rdata[2:0] = st_r.int_mask;
      end else begin
        st_nxt.rresp = `RESP_SLVERR;
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus engine; hardware events come after software so that they win
    case (st_r.phase)
      i2c_hold_pkg::PH_ADDR, i2c_hold_pkg::PH_RX: begin
        if (scl_rise) begin
          st_nxt.shift = {st_r.shift[6:0], sda_s};
          st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
        end
        if (byte_end) begin
          if (st_r.phase == i2c_hold_pkg::PH_ADDR && st_r.shift[7:1] != st_r.own_addr) begin
            st_nxt.phase = i2c_hold_pkg::PH_IDLE;
          end else begin
            st_nxt.acked = accept;
            st_nxt.phase = (st_r.phase == i2c_hold_pkg::PH_ADDR) ? i2c_hold_pkg::PH_ADDR_ACK
                                                                 : i2c_hold_pkg::PH_RX_ACK;
            if (st_r.phase == i2c_hold_pkg::PH_ADDR) begin
              st_nxt.rw = st_r.shift[0];
            end
            if (accept) begin
              st_nxt.rcv = st_r.shift;
              st_nxt.receive_buffer_full = 1'b1;
              st_nxt.sda_want = 1'b0;
              st_nxt.int_stat[`INT_RX_BIT] = 1'b1;
            end else begin
              st_nxt.ov = 1'b1;
            end
            if ((st_r.phase == i2c_hold_pkg::PH_ADDR && st_r.options[`OPT_ADDR_HOLD_BIT])
                || (st_r.phase == i2c_hold_pkg::PH_RX && st_r.options[`OPT_DATA_HOLD_BIT])) begin
              st_nxt.clock_release = 1'b0;
              st_nxt.int_stat[`INT_HOLD_BIT] = 1'b1;
            end
          end
        end
      end
      i2c_hold_pkg::PH_ADDR_ACK, i2c_hold_pkg::PH_RX_ACK: begin
        if (scl_fall) begin
          st_nxt.sda_want = 1'b1;
          st_nxt.bit_cnt = 4'h0;
          if (!st_r.acked) begin
            st_nxt.phase = i2c_hold_pkg::PH_IDLE;
          end else if (st_r.phase == i2c_hold_pkg::PH_ADDR_ACK && st_r.rw) begin
            st_nxt.phase = i2c_hold_pkg::PH_TX;
            st_nxt.shift = st_r.tx_byte;
            st_nxt.sda_want = st_r.tx_byte[7];
          end else begin
            st_nxt.phase = i2c_hold_pkg::PH_RX;
          end
        end
      end
      i2c_hold_pkg::PH_TX: begin
        if (scl_rise) begin
          st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
        end
        if (byte_end) begin
          st_nxt.sda_want = 1'b1;
          st_nxt.phase = i2c_hold_pkg::PH_TX_ACK;
        end else if (scl_fall) begin
          st_nxt.shift = {st_r.shift[6:0], 1'b0};
          st_nxt.sda_want = st_r.shift[6];
        end
      end
      i2c_hold_pkg::PH_TX_ACK: begin
        if (scl_rise) begin
          st_nxt.acked = ~sda_s;
        end
        if (scl_fall) begin
          st_nxt.bit_cnt = 4'h0;
          st_nxt.phase = st_r.acked ? i2c_hold_pkg::PH_TX : i2c_hold_pkg::PH_IDLE;
          st_nxt.shift = st_r.tx_byte;
          st_nxt.sda_want = st_r.acked ? st_r.tx_byte[7] : 1'b1;
        end
      end
      default: begin
        st_nxt.sda_want = 1'b1;
      end
    endcase

    if (coll_ev) begin
      st_nxt.bus_collision_flag = 1'b1;
      st_nxt.int_stat[`INT_COLLISION_BIT] = 1'b1;
    end
    if (start_ev) begin
      st_nxt.phase = i2c_hold_pkg::PH_ADDR;
      st_nxt.bit_cnt = 4'h0;
      st_nxt.sda_want = 1'b1;
    end
    if (coll_ev || stop_ev || !st_r.enable) begin
      st_nxt.phase = i2c_hold_pkg::PH_IDLE;
      st_nxt.sda_want = 1'b1;
    end
    if (!st_r.enable) begin
      st_nxt.clock_release = 1'b1;
    end

    // New SDA level waits out the hold time after each SCL fall
    if (st_nxt.phase == i2c_hold_pkg::PH_IDLE) begin
      st_nxt.sda_low = 1'b0;
    end else if (!hold_busy && !scl_fall) begin
      st_nxt.sda_low = ~st_r.sda_want;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      st_r <= '0;
      st_r.phase <= i2c_hold_pkg::PH_IDLE;
      st_r.own_addr <= `OWN_ADDR_RST;
      st_r.options <= `OPTIONS_RST;
      st_r.clock_release <= 1'b1;
      st_r.scl_prev <= 1'b1;
      st_r.sda_prev <= 1'b1;
      st_r.sda_want <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign o_awready = ~st_r.aw_got & ~st_r.bvalid;
  assign o_wready = ~st_r.w_got & ~st_r.bvalid;
  assign o_bvalid = st_r.bvalid;
  assign o_bresp = st_r.bresp;
  assign o_arready = ~st_r.rvalid;
  assign o_rvalid = st_r.rvalid;
  assign o_rdata = st_r.rdata;
  assign o_rresp = st_r.rresp;
  assign o_irq = |(st_r.int_stat & st_r.int_mask);
  assign o_scl = 1'b0;
  assign o_sda = 1'b0;
  // Stretching is simply the release bit being low
  assign o_scl_oe = ~st_r.clock_release;
  assign o_sda_oe = st_r.sda_low;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  sequence rx_data_end;
    st_r.phase == i2c_hold_pkg::PH_RX && byte_end && !coll_ev && !stop_ev && st_r.enable;
  endsequence
  sequence addr_match_end;
    st_r.phase == i2c_hold_pkg::PH_ADDR && byte_end && st_r.shift[7:1] == st_r.own_addr && st_r.enable
    && !stop_ev;
  endsequence

  a_overwrite_load: assert property (rx_data_end and (st_r.options[4] && !st_r.receive_buffer_full) |=> st_r.receive_buffer_full && st_r.rcv == $past(st_r.shift))
    else $error("overwrite mode did not load free buffer");
  a_overflow_block: assert property (rx_data_end and (!st_r.options[4] && st_r.ov) |=> st_r.rcv == $past(st_r.rcv) && st_r.ov)
    else $error("receive register changed while overflow set");
  a_hold_long: assert property (scl_fall && st_r.options[3] && !(st_r.phase == i2c_hold_pkg::PH_IDLE) |=> ($stable(o_sda_oe) || !o_sda_oe)[*8])
    else $error("SDA driven low too soon after SCL fall");
  a_hold_short: assert property (scl_fall && !coll_ev && !stop_ev && !start_ev |=> $stable(o_sda_oe)[*3])
    else $error("SDA changed inside short hold time");
  a_collision_idle: assert property (coll_ev |=> st_r.bus_collision_flag && st_r.phase == i2c_hold_pkg::PH_IDLE && !o_sda_oe)
    else $error("collision did not set flag and idle the bus");
  a_collision_phase: assert property ($rose(st_r.bus_collision_flag) |-> $past(tx_phase) && $past(st_r.options[2]))
    else $error("collision flagged outside transmit phases");
  a_collision_irq: assert property ($rose(st_r.int_stat[1]) |-> $past(st_r.options[2]) && st_r.bus_collision_flag)
    else $error("collision interrupt without detection enabled");
  a_addr_hold: assert property (addr_match_end and st_r.options[1] |=> !st_r.clock_release && o_scl_oe)
    else $error("address hold did not stretch SCL");
  a_data_hold: assert property (rx_data_end and st_r.options[0] |=> !st_r.clock_release ##1 o_scl_oe)
    else $error("data hold did not stretch SCL");
  a_no_data_hold: assert property (rx_data_end and (!st_r.options[0] && st_r.clock_release && !(st_r.aw_got && st_r.w_got)) |=> st_r.clock_release)
    else $error("SCL stretched with data hold disabled");

endmodule

`default_nettype wire

//--- test/i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model #(
  parameter int T_HIGH = 100,
  parameter int T_LOW = 600
) (
  // Resolved bus levels
  input wire logic i_scl,
  input wire logic i_sda,
  // Pull-downs onto the bus
  output logic o_scl_low,
  output logic o_sda_low
);
  // Low phase kept long: slave hold plus its input sync must land inside it
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end

  task automatic clock_bit(input logic pull, output logic seen);
    int n;
    n = 0;
    #50;
    o_sda_low = pull;
    #(T_LOW - 50);
    o_scl_low = 1'b0;
    while (i_scl !== 1'b1 && n < 40000) begin
      #25;
      n++;
    end
    #(T_HIGH);
    seen = i_sda;
    o_scl_low = 1'b1;
  endtask

  task automatic start_cond();
    o_sda_low = 1'b1;
    #(T_HIGH);
    o_scl_low = 1'b1;
  endtask

  task automatic stop_cond();
    #50;
    o_sda_low = 1'b1;
    #(T_LOW);
    o_scl_low = 1'b0;
    #(T_HIGH);
    o_sda_low = 1'b0;
    #(T_HIGH);
  endtask

  task automatic write_byte(input logic [7:0] v, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(~v[i], s);
    end
    clock_bit(1'b0, nack);
  endtask

  // Collide pulls SDA low in every data slot
  task automatic read_byte(input logic collide, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(collide, s);
      v[i] = s;
    end
    clock_bit(1'b0, s);
  endtask
endmodule

`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2c_hold_params.svh"

module tb;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, b;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic scl_o, scl_oe, sda_o, sda_oe, irq, m_scl, m_sda, nk;
  wire logic scl_bus, sda_bus;
  int failures = 0, n_tests = 0, cycles = 0, n_stretch = 0, n0;
  realtime t_fall, hold_min;

  // Open-drain lines with pull-ups
  assign scl_bus = ~((scl_oe & ~scl_o) | m_scl);
  assign sda_bus = ~((sda_oe & ~sda_o) | m_sda);

  i2c_slave_hold i2c_slave_hold_inst (.i_ref_clk(clk), .i_reset(rst), .i_scl(scl_bus), .o_scl(scl_o),
    .o_scl_oe(scl_oe), .i_sda(sda_bus), .o_sda(sda_o), .o_sda_oe(sda_oe), .i_awvalid(awvalid),
    .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
    .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid),
    .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
    .o_rresp(rresp), .o_irq(irq));
  i2c_master_model i2c_master_model_inst (.i_scl(scl_bus), .i_sda(sda_bus), .o_scl_low(m_scl),
    .o_sda_low(m_sda));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(negedge scl_bus) t_fall = $realtime;
  always @(sda_oe) if (hold_min > 0) check("sda hold", {31'h0, $realtime - t_fall >= hold_min}, 1);
  always @(posedge scl_oe) n_stretch++;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] rs;
    axi_wr(a, v, rs);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0] rs;
    axi_rd(a, v, rs);
    check(what, v & m, exp);
  endtask

  task automatic wait_oe(input logic v);
    int n;
    n = 0;
    while (scl_oe !== v && n < 4000) begin
      @(posedge clk);
      n++;
    end
    check("scl stretch", {31'h0, scl_oe}, {31'h0, v});
  endtask

  // One byte from the master, with the acknowledge it must see
  task automatic send(input logic [7:0] v, input logic exp_nack);
    i2c_master_model_inst.write_byte(v, nk);
    check("ack slot", {31'h0, nk}, {31'h0, exp_nack});
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    hold_min = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_chk("ctrl lo", `REG_CTRL_LO, ALL, 32'h00001000);
    rd_chk("own addr", `REG_OWN_ADDR, ALL, 32'h0000002A);
    axi_rd(8'h40, d, r);
    check("unmapped rd", {30'h0, r}, {30'h0, `RESP_SLVERR});
    axi_wr(8'h40, 32'h0000FFFF, r);
    check("unmapped wr", {30'h0, r}, {30'h0, `RESP_SLVERR});
    wr(`REG_CTRL_LO, 32'h00009000);
    $display("test registers done");
    // Overwrite off: address fills the buffer, data is refused, overflow blocks the next byte
    i2c_master_model_inst.start_cond();
    send(8'h54, 1'b0);
    send(8'hA5, 1'b1);
    i2c_master_model_inst.stop_cond();
    check("irq masked", {31'h0, irq}, 0);
    rd_chk("status", `REG_STATUS, ALL, 32'h00000042);
    rd_chk("receive", `REG_RECEIVE, ALL, 32'h00000054);
    wr(`REG_OWN_ADDR, 32'h00000015);
    i2c_master_model_inst.start_cond();
    send(8'h2A, 1'b1);
    i2c_master_model_inst.stop_cond();
    rd_chk("receive kept", `REG_RECEIVE, ALL, 32'h00000054);
    $display("test no overwrite done");
    // Overwrite on with overflow still set, address and data holds
    wr(`REG_INT_MASK, 32'h00000004);
    wr(`REG_CTRL_HI, 32'h0000001B);
    fork
      begin
        i2c_master_model_inst.start_cond();
        send(8'h2A, 1'b0);
        send(8'h3C, 1'b0);
        i2c_master_model_inst.stop_cond();
      end
      begin
        wait_oe(1'b1);
        check("hold irq", {31'h0, irq}, 1);
        rd_chk("release clr", `REG_CTRL_LO, ALL, 32'h00008000);
        rd_chk("rx addr", `REG_RECEIVE, ALL, 32'h0000002A);
        wr(`REG_CTRL_LO, 32'h00009000);
        wait_oe(1'b0);
        wait_oe(1'b1);
        rd_chk("release clr", `REG_CTRL_LO, ALL, 32'h00008000);
        rd_chk("rx data", `REG_RECEIVE, ALL, 32'h0000003C);
        wr(`REG_CTRL_LO, 32'h00009000);
      end
    join
    wr(`REG_INT_STAT, 32'h00000007);
    check("irq cleared", {31'h0, irq}, 0);
    $display("test holds done");
    // Both hold times, holds off, detection on while the slave drives only the address acknowledge
    n0 = n_stretch;
    for (int h = 0; h < 2; h++) begin
      wr(`REG_CTRL_HI, (h == 1) ? 32'h0000001C : 32'h00000014);
      hold_min = (h == 1) ? 300 : 100;
      i2c_master_model_inst.start_cond();
      send(8'h2A, 1'b0);
      send(8'h11, 1'b1);
      i2c_master_model_inst.stop_cond();
      hold_min = 0;
      rd_chk("rx addr", `REG_RECEIVE, ALL, 32'h0000002A);
    end
    check("no stretch", n_stretch - n0, 0);
    rd_chk("no collision", `REG_STATUS, 32'h00000400, 0);
    $display("test hold time done");
    // Master pulls SDA low against a transmitted one, detection off then on
    wr(`REG_TRANSMIT, 32'h000000FF);
    wr(`REG_INT_MASK, 32'h00000002);
    for (int c = 0; c < 2; c++) begin
      wr(`REG_CTRL_HI, (c == 1) ? 32'h00000014 : 32'h00000010);
      i2c_master_model_inst.start_cond();
      send(8'h2B, 1'b0);
      i2c_master_model_inst.read_byte(1'b1, b);
      i2c_master_model_inst.stop_cond();
      check("sda idle", {31'h0, sda_oe}, 0);
      rd_chk("collision", `REG_STATUS, 32'h00000400, (c == 1) ? 32'h00000400 : 0);
      rd_chk("coll int", `REG_INT_STAT, 32'h00000002, (c == 1) ? 32'h00000002 : 0);
      check("coll irq", {31'h0, irq}, c);
      rd_chk("rx addr", `REG_RECEIVE, ALL, 32'h0000002B);
    end
    $display("test collision done");
    end_of_test();
  end
endmodule

`default_nettype wire
